// File: hdl/dual_agu_defines.vh
// Constants for the dual address generator: register offsets, reset
// values, field positions and addressing-mode codes.
// Assumes inclusion by bare name from a design file; definitions only.
//
// Function
// - Separate X and Y generators, same cycle
// - Y path: word reads, multiply-accumulate only
// - Linear, circular and bit-reversed addressing schemes
// - Bit-reversed applies to data space only
// - File-register address is 13 bits, near space
// - File-register operand is working register zero
// - Results to file register, W0, or pair
// - Move reaches the whole data space
// - Register direct yields register content, no address
// - Indirect: address is pointer, pointer unchanged
// - Post-modify: use pointer, then step it
// - Pre-modify: step pointer, then use it
// - Address is pointer plus offset register
// - Address is pointer plus instruction literal
// - Three-operand first source is register direct
// - Second source: register, memory or 5-bit literal
// - Three-operand result to register or memory
// - Arithmetic modes plus 5- or 10-bit literals
// - X circular needs select not 15, bit 15
// - Y select bits 7:4, enable bit 14
// - Bit-reverse needs select, enable, increment mode
`ifndef DUAL_AGU_DEFINES_VH
`define DUAL_AGU_DEFINES_VH

// Register byte offsets
`define OFS_DEFAULT_WORKING_REGISTER_LAST      16'h001E
`define OFS_CORE_CONTROL   16'h0044
`define OFS_CIRC_CONTROL   16'h0046
`define OFS_X_START        16'h0048
`define OFS_X_END          16'h004A
`define OFS_Y_START        16'h004C
`define OFS_Y_END          16'h004E
`define OFS_X_REVERSE      16'h0050
`define OFS_HOLD_COUNT     16'h0052

// Reset values
`define RST_CORE_CONTROL   16'h0020
`define RST_CIRC_CONTROL   16'h0000
`define RST_DEFAULT_WORKING_REGISTER           16'h0000
`define RST_STACK_PTR      16'h0800
`define RST_HOLD_COUNT     16'h0000
`define RST_BOUND          16'h0000

// Field positions in the circular/bit-reverse control register
`define X_CIRC_EN_BIT      15
`define Y_CIRC_EN_BIT      14
`define REV_SEL_HI         11
`define REV_SEL_LO         8
`define Y_SEL_HI           7
`define Y_SEL_LO           4
`define X_SEL_HI           3
`define X_SEL_LO           0
`define SEL_DISABLED       4'hF
// Bit-reverse register: enable on top, pivot below
`define REV_EN_BIT         15
`define CORE_CTL_MASK      16'h1FFF
`define HOLD_COUNT_MASK    16'h3FFF

// Near data space width of a file-register address
`define NEAR_ADDR_BITS     13

// X path addressing modes
`define XM_FILE            3'h0
`define XM_DIRECT          3'h1
`define XM_INDIRECT        3'h2
`define XM_POST            3'h3
`define XM_PRE             3'h4
`define XM_REG_OFS         3'h5
`define XM_LIT_OFS         3'h6
`define XM_LITERAL         3'h7

// Y path addressing modes
`define YM_INDIRECT        2'h0
`define YM_POST            2'h1
`define YM_REG_OFS         2'h2

// Pointer steps in bytes
`define STEP_BYTE          16'h0001
`define STEP_WORD          16'h0002

`endif

// File: hdl/dual_address_generator.v
// Dual effective-address generator with working register array and the
// circular / bit-reverse control registers.
// Assumes requests come from instruction decode on mclk, one per path per
// cycle, and that data memory sits outside and uses the addresses given.
`timescale 1ns/1ps
`include "dual_agu_defines.vh"

module dual_address_generator
(
   // Clock and reset
   input  wire        mclk,
   input  wire        rst_n,
   // Register port
   input  wire [15:0] reg_addr,
   input  wire [15:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [15:0] reg_rdata,
   // X path request
   input  wire        x_req,
   input  wire [2:0]  x_mode,
   input  wire [3:0]  x_ptr_sel,
   input  wire [3:0]  x_ofs_sel,
   input  wire [9:0]  x_lit,
   input  wire        x_lit_wide,
   input  wire        x_dec,
   input  wire        x_byte,
   input  wire        x_prog_space,
   input  wire [15:0] x_file_addr,
   input  wire        x_is_move,
   // X path answer
   output reg         x_valid,
   output reg         x_mem,
   output reg  [15:0] x_ea,
   output reg  [15:0] x_operand,
   // Y path request
   input  wire        y_req,
   input  wire        y_mac,
   input  wire [1:0]  y_mode,
   input  wire [3:0]  y_ptr_sel,
   input  wire [3:0]  y_ofs_sel,
   input  wire        y_dec,
   // Y path answer
   output reg         y_valid,
   output reg  [15:0] y_ea,
   // Three-operand first source
   input  wire [3:0]  src1_sel,
   output reg  [15:0] src1_data,
   output reg  [15:0] default_working_register,
   // Result write-back
   input  wire        wb_wr,
   input  wire        wb_to_default,
   input  wire        wb_pair,
   input  wire [3:0]  wb_sel,
   input  wire [15:0] wb_data,
   input  wire [15:0] wb_data_hi
);

   // Working registers and control registers
   reg  [15:0] default_working_register_q [0:15];
   reg  [15:0] core_control_q;
   reg  [15:0] circular_bitrev_control_q;
   reg  [15:0] x_start_q;
   reg  [15:0] x_end_q;
   reg  [15:0] y_start_q;
   reg  [15:0] y_end_q;
   reg  [15:0] x_reverse_q;
   reg  [15:0] hold_count_q;

   integer     i;

   // Wrap a stepped pointer back into [s, e]; overshoot is corrected too
   function [15:0] circ_fix;
      input [15:0] v;
      input [15:0] s;
      input [15:0] e;
      reg   [15:0] len;
      begin
         len = e - s + 16'h0001;
         if (v > e)
            circ_fix = v - len;
         else if (v < s)
            circ_fix = v + len;
         else
            circ_fix = v;
      end
   endfunction

   // Reverse-carry add on word addresses; pivot scaled to bytes
   function [15:0] rev_add;
      input [15:0] p;
      input [14:0] pivot;
      reg   [14:0] a;
      reg   [14:0] b;
      reg   [14:0] r;
      integer      k;
      begin
         a = 15'h0000;
         b = 15'h0000;
         for (k = 0; k < 15; k = k + 1)
         begin
            a[k] = p[15 - k];
            b[k] = pivot[14 - k];
         end
         r = a + b;
         for (k = 0; k < 15; k = k + 1)
            a[14 - k] = r[k];
         rev_add = {a, 1'b0};
      end
   endfunction

   // Control fields
   wire        x_circ_en  = circular_bitrev_control_q[`X_CIRC_EN_BIT];
   wire        y_circ_en  = circular_bitrev_control_q[`Y_CIRC_EN_BIT];
   wire [3:0]  x_pointer_select =
      circular_bitrev_control_q[`X_SEL_HI:`X_SEL_LO];
   wire [3:0]  y_pointer_select =
      circular_bitrev_control_q[`Y_SEL_HI:`Y_SEL_LO];
   wire [3:0]  reverse_pointer_select =
      circular_bitrev_control_q[`REV_SEL_HI:`REV_SEL_LO];
   wire        reverse_enable = x_reverse_q[`REV_EN_BIT];
   wire [14:0] reverse_pivot_value = x_reverse_q[14:0];

   // X path operands
   wire [15:0] x_pointer_register = default_working_register_q[x_ptr_sel];
   wire [15:0] x_offset_register  = default_working_register_q[x_ofs_sel];
   wire [15:0] x_step  = x_byte ? `STEP_BYTE : `STEP_WORD;
   wire [15:0] x_stepped = x_dec ? x_pointer_register - x_step
                                 : x_pointer_register + x_step;
   wire        x_modify = (x_mode == `XM_POST) || (x_mode == `XM_PRE);

   wire        x_circ = x_circ_en
                     && (x_pointer_select != `SEL_DISABLED)
                     && (x_ptr_sel == x_pointer_select);
   // Bit-reverse only steps upward and never in program space
   wire        x_rev  = reverse_enable
                     && (reverse_pointer_select != `SEL_DISABLED)
                     && (x_ptr_sel == reverse_pointer_select)
                     && x_modify && !x_dec
                     && !x_prog_space;

   reg  [15:0] x_new_ptr;
   reg  [15:0] x_ea_d;
   reg  [15:0] x_operand_d;
   reg         x_mem_d;
   reg  [15:0] x_sum;

   always @*
   begin
      x_new_ptr   = x_pointer_register;
      x_ea_d      = 16'h0000;
      x_operand_d = 16'h0000;
      x_mem_d     = 1'b1;
      x_sum       = 16'h0000;
      // Three schemes: linear, circular, bit-reversed
      if (x_rev)
         x_new_ptr = rev_add(x_pointer_register, reverse_pivot_value);
      else if (x_circ)
         x_new_ptr = circ_fix(x_stepped, x_start_q, x_end_q);
      else
         x_new_ptr = x_stepped;
      case (x_mode)
         `XM_FILE:
         begin
            if (x_is_move)
               x_ea_d = x_file_addr;
            else
               x_ea_d = {3'b000,
                         x_file_addr[`NEAR_ADDR_BITS-1:0]};
            x_operand_d = default_working_register_q[0];
         end
         `XM_DIRECT:
         begin
            x_mem_d     = 1'b0;
            x_operand_d = x_pointer_register;
         end
         `XM_INDIRECT:
            x_ea_d = x_pointer_register;
         `XM_POST:
            x_ea_d = x_pointer_register;
         `XM_PRE:
            x_ea_d = x_new_ptr;
         `XM_REG_OFS:
         begin
            x_sum = x_pointer_register + x_offset_register;
            // Offset result is wrapped but never written back
            x_ea_d = x_circ ? circ_fix(x_sum, x_start_q, x_end_q) : x_sum;
         end
         `XM_LIT_OFS:
         begin
            x_sum = x_pointer_register + {6'h00, x_lit};
            x_ea_d = x_circ ? circ_fix(x_sum, x_start_q, x_end_q) : x_sum;
         end
         `XM_LITERAL:
         begin
            x_mem_d = 1'b0;
            if (x_lit_wide)
               x_operand_d = {6'h00, x_lit};
            else
               x_operand_d = {11'h000, x_lit[4:0]};
         end
         default:
            x_mem_d = 1'b0;
      endcase
   end

   // Y path: word-aligned, multiply-accumulate reads only
   wire        y_go = y_req && y_mac;
   wire [15:0] y_pointer_register = default_working_register_q[y_ptr_sel];
   wire [15:0] y_offset_register  = default_working_register_q[y_ofs_sel];
   wire        y_circ = y_circ_en
                     && (y_pointer_select != `SEL_DISABLED)
                     && (y_ptr_sel == y_pointer_select);
   wire [15:0] y_stepped = y_dec ? y_pointer_register - `STEP_WORD
                                 : y_pointer_register + `STEP_WORD;
   wire [15:0] y_sum = y_pointer_register + y_offset_register;

   reg  [15:0] y_new_ptr;
   reg  [15:0] y_ea_d;
   reg         y_upd;

   always @*
   begin
      y_new_ptr = y_circ ? circ_fix(y_stepped, y_start_q, y_end_q)
                         : y_stepped;
      y_upd     = 1'b0;
      case (y_mode)
         `YM_INDIRECT:
            y_ea_d = y_pointer_register;
         `YM_POST:
         begin
            y_ea_d = y_pointer_register;
            y_upd  = 1'b1;
         end
         `YM_REG_OFS:
            y_ea_d = y_circ ? circ_fix(y_sum, y_start_q, y_end_q) : y_sum;
         default:
            y_ea_d = y_pointer_register;
      endcase
      y_ea_d[0] = 1'b0;
   end

   wire x_upd = x_req && x_modify;

   // Answers: both paths computed in the same cycle
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         x_valid   <= 1'b0;
         x_mem     <= 1'b0;
         x_ea      <= 16'h0000;
         x_operand <= 16'h0000;
         y_valid   <= 1'b0;
         y_ea      <= 16'h0000;
         src1_data <= 16'h0000;
         default_working_register <= 16'h0000;
      end
      else
      begin
         x_valid   <= x_req;
         y_valid   <= y_go;
         if (x_req)
         begin
            x_mem     <= x_mem_d;
            x_ea      <= x_ea_d;
            x_operand <= x_operand_d;
         end
         if (y_go)
            y_ea <= y_ea_d;
         src1_data <= default_working_register_q[src1_sel];
         default_working_register <= default_working_register_q[0];
      end
   end

   // Working registers: later assignments win, so the register port
   // beats write-back, which beats pointer update on the same register
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (i = 0; i < 15; i = i + 1)
            default_working_register_q[i] <= `RST_DEFAULT_WORKING_REGISTER;
         default_working_register_q[15] <= `RST_STACK_PTR;
      end
      else
      begin
         if (y_go && y_upd)
            default_working_register_q[y_ptr_sel] <= y_new_ptr;
         if (x_upd)
            default_working_register_q[x_ptr_sel] <= x_new_ptr;
         if (wb_wr)
         begin
            if (wb_to_default)
               default_working_register_q[0] <= wb_data;
            else
               default_working_register_q[wb_sel] <= wb_data;
            if (wb_pair && !wb_to_default)
               default_working_register_q[wb_sel + 4'h1] <= wb_data_hi;
         end
         if (reg_wr && (reg_addr <= `OFS_DEFAULT_WORKING_REGISTER_LAST))
            default_working_register_q[reg_addr[4:1]] <= reg_wdata;
      end
   end

   // Control registers
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         core_control_q            <= `RST_CORE_CONTROL;
         circular_bitrev_control_q <= `RST_CIRC_CONTROL;
         x_start_q                 <= `RST_BOUND;
         x_end_q                   <= `RST_BOUND | 16'h0001;
         y_start_q                 <= `RST_BOUND;
         y_end_q                   <= `RST_BOUND | 16'h0001;
         x_reverse_q               <= `RST_BOUND;
         hold_count_q              <= `RST_HOLD_COUNT;
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            `OFS_CORE_CONTROL:
               core_control_q <= reg_wdata & `CORE_CTL_MASK;
            `OFS_CIRC_CONTROL:
               circular_bitrev_control_q <= reg_wdata & 16'hCFFF;
            // Start bounds are even, end bounds odd
            `OFS_X_START:
               x_start_q <= {reg_wdata[15:1], 1'b0};
            `OFS_X_END:
               x_end_q <= {reg_wdata[15:1], 1'b1};
            `OFS_Y_START:
               y_start_q <= {reg_wdata[15:1], 1'b0};
            `OFS_Y_END:
               y_end_q <= {reg_wdata[15:1], 1'b1};
            `OFS_X_REVERSE:
               x_reverse_q <= reg_wdata;
            `OFS_HOLD_COUNT:
               hold_count_q <= reg_wdata & `HOLD_COUNT_MASK;
            default:
               hold_count_q <= hold_count_q;
         endcase
      end
   end

   // Read data: one cycle after the strobe, zero otherwise
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata <= 16'h0000;
      else if (!reg_rd)
         reg_rdata <= 16'h0000;
      else if (reg_addr <= `OFS_DEFAULT_WORKING_REGISTER_LAST)
         reg_rdata <= {15'h0000, 1'b0} | default_working_register_q[reg_addr[4:1]];
      else
      begin
         case (reg_addr)
            `OFS_CORE_CONTROL: reg_rdata <= core_control_q;
            `OFS_CIRC_CONTROL: reg_rdata <= circular_bitrev_control_q;
            `OFS_X_START:      reg_rdata <= x_start_q;
            `OFS_X_END:        reg_rdata <= x_end_q;
            `OFS_Y_START:      reg_rdata <= y_start_q;
            `OFS_Y_END:        reg_rdata <= y_end_q;
            `OFS_X_REVERSE:    reg_rdata <= x_reverse_q;
            `OFS_HOLD_COUNT:   reg_rdata <= hold_count_q;
            default:           reg_rdata <= 16'h0000;
         endcase
      end
   end

endmodule // dual_address_generator

// File: sim/dual_agu_checker_assertions.sv
// Timing and value checks on the answer ports of the dual address generator.
// Assumes the bind below and the single mclk domain.
`timescale 1ns/1ps
module dual_agu_checker
(
   // Clock and reset
   input wire        mclk,
   input wire        rst_n,
   // X path
   input wire        x_req,
   input wire [2:0]  x_mode,
   input wire [9:0]  x_lit,
   input wire        x_lit_wide,
   input wire [15:0] x_file_addr,
   input wire        x_is_move,
   input wire        x_valid,
   input wire        x_mem,
   input wire [15:0] x_ea,
   input wire [15:0] x_operand,
   // Y path
   input wire        y_req,
   input wire        y_mac,
   input wire        y_valid,
   input wire [15:0] y_ea
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   x_answer_a: assert property (x_req |=> x_valid)
      else $error("x answer missing");
   x_quiet_a: assert property (!x_req |=> !x_valid)
      else $error("x answer without request");
   y_taken_a: assert property (y_req && y_mac |=> y_valid)
      else $error("y answer missing");
   y_refused_a: assert property (!(y_req && y_mac) |=> !y_valid)
      else $error("y answer outside mac");
   y_word_a: assert property (y_valid |-> !y_ea[0])
      else $error("y address not word aligned");
   near_addr_a: assert property (x_req && x_mode == 3'h0 && !x_is_move |=>
      x_mem && x_ea == ($past(x_file_addr) & 16'h1FFF))
      else $error("near address wrong");
   move_addr_a: assert property (x_req && x_mode == 3'h0 && x_is_move |=>
      x_ea == $past(x_file_addr)) else $error("move address wrong");
   direct_a: assert property (x_req && x_mode == 3'h1 |=> !x_mem)
      else $error("direct mode gave an address");
   short_lit_a: assert property (x_req && x_mode == 3'h7 && !x_lit_wide |=>
      !x_mem && x_operand == ({6'h00, $past(x_lit)} & 16'h001F))
      else $error("short literal wrong");
   wide_lit_a: assert property (x_req && x_mode == 3'h7 && x_lit_wide |=>
      x_operand == {6'h00, $past(x_lit)}) else $error("wide literal wrong");
endmodule // dual_agu_checker

bind dual_address_generator dual_agu_checker chk_u
(
   .mclk, .rst_n, .x_req, .x_mode, .x_lit, .x_lit_wide, .x_file_addr,
   .x_is_move, .x_valid, .x_mem, .x_ea, .x_operand, .y_req, .y_mac,
   .y_valid, .y_ea
);

// File: sim/agu_data_memory.sv
// Data memory stand-in for the Y path: logs each word read it is given.
// Assumes y_valid is a one-cycle pulse on mclk.
`timescale 1ns/1ps
module agu_data_memory
(
   // Clock and reset
   input wire        mclk,
   input wire        rst_n,
   // Y read address
   input wire        y_valid,
   input wire [15:0] y_ea,
   // Access log
   output reg [7:0]  y_count,
   output reg [15:0] y_last
);
   // A count, not a flag, so a doubled pulse shows up as well
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         y_count <= 8'h00;
         y_last  <= 16'h0000;
      end
      else if (y_valid)
      begin
         y_count <= y_count + 8'h01;
         y_last  <= y_ea;
      end
   end
endmodule // agu_data_memory

// File: sim/test_dual_address_generator.sv
// Self-checking bench for the dual address generator.
// Assumes the checker bind and the data memory model are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) \
   begin \
      checked++; \
      if ((a) !== (b)) \
      begin \
         n_fail++; \
         $display("unexpected at %0t: got %h want %h", $time, a, b); \
      end \
   end
module test_dual_address_generator;
   logic        mclk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic        x_req = 1'b0, y_req = 1'b0, x_lit_wide = 1'b0;
   logic        x_dec = 1'b0, x_byte = 1'b0, x_prog_space = 1'b0;
   logic        x_is_move = 1'b0, y_mac = 1'b0, y_dec = 1'b0;
   logic        wb_wr = 1'b0, wb_to_default = 1'b0, wb_pair = 1'b0;
   logic [1:0]  y_mode = 2'h0;
   logic [2:0]  x_mode = 3'h0;
   logic [3:0]  x_ptr_sel = 4'h0, x_ofs_sel = 4'h3, y_ptr_sel = 4'h0;
   logic [3:0]  y_ofs_sel = 4'h0, src1_sel = 4'h0, wb_sel = 4'h0;
   logic [9:0]  x_lit = 10'h000;
   logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000;
   logic [15:0] x_file_addr = 16'h0000, wb_data = 16'h0000;
   logic [15:0] wb_data_hi = 16'h0000, rd_q, y_last;
   logic        x_valid, x_mem, y_valid;
   logic [15:0] reg_rdata, x_ea, x_operand, y_ea, src1_data;
   logic [15:0] default_working_register;
   logic [7:0]  y_count;
   int          n_fail = 0;
   int          checked = 0;
   // Address, reset value, value read after writing all ones
   logic [15:0] ra [10] = '{16'h0044, 16'h0046, 16'h0048, 16'h004A,
      16'h004C, 16'h004E, 16'h0050, 16'h0052, 16'h001E, 16'h0060};
   logic [15:0] rv [10] = '{16'h0020, 16'h0000, 16'h0000, 16'h0001,
      16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0800, 16'h0000};
   logic [15:0] rm [10] = '{16'h1FFF, 16'hCFFF, 16'hFFFE, 16'hFFFF,
      16'hFFFE, 16'hFFFF, 16'hFFFF, 16'h3FFF, 16'h0000, 16'h0000};

   dual_address_generator dut_u
   (
      .mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .x_req, .x_mode, .x_ptr_sel, .x_ofs_sel, .x_lit, .x_lit_wide,
      .x_dec, .x_byte, .x_prog_space, .x_file_addr, .x_is_move,
      .x_valid, .x_mem, .x_ea, .x_operand, .y_req, .y_mac, .y_mode,
      .y_ptr_sel, .y_ofs_sel, .y_dec, .y_valid, .y_ea, .src1_sel,
      .src1_data, .default_working_register, .wb_wr, .wb_to_default,
      .wb_pair, .wb_sel, .wb_data, .wb_data_hi
   );

   agu_data_memory mem_u
   (
      .mclk, .rst_n, .y_valid, .y_ea, .y_count, .y_last
   );

   always #20 mclk = ~mclk;

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic wr(input [15:0] a, input [15:0] d);
      @(posedge mclk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr    <= 1'b0;
   endtask

   task automatic rchk(input [15:0] a, input [15:0] e);
      @(posedge mclk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd   <= 1'b0;
      #1;
      `CHK(reg_rdata, e)
   endtask

   // fl holds move, wide literal, decrement, byte
   task automatic xs(input [2:0] m, input [3:0] p, input [9:0] l,
                     input [3:0] fl, input [15:0] f);
      x_req       <= 1'b1;
      x_mode      <= m;
      x_ptr_sel   <= p;
      x_lit       <= l;
      x_is_move   <= fl[3];
      x_lit_wide  <= fl[2];
      x_dec       <= fl[1];
      x_byte      <= fl[0];
      x_file_addr <= f;
   endtask

   task automatic ys(input mac, input [1:0] m, input [3:0] p);
      y_req     <= 1'b1;
      y_mac     <= mac;
      y_mode    <= m;
      y_ptr_sel <= p;
   endtask

   // Drops both requests and lets the answer edge's updates land
   task automatic go;
      @(posedge mclk);
      x_req <= 1'b0;
      y_req <= 1'b0;
      #1;
   endtask

   task automatic xop(input [2:0] m, input [3:0] p, input [9:0] l,
                      input [3:0] fl, input [15:0] f);
      @(posedge mclk);
      xs(m, p, l, fl, f);
      go;
      `CHK(x_valid, 1'b1)
   endtask

   task automatic wbw(input td, input pr, input [3:0] s,
                      input [15:0] d, input [15:0] dh);
      @(posedge mclk);
      wb_wr         <= 1'b1;
      wb_to_default <= td;
      wb_pair       <= pr;
      wb_sel        <= s;
      wb_data       <= d;
      wb_data_hi    <= dh;
      @(posedge mclk);
      wb_wr         <= 1'b0;
   endtask

   initial
   begin
      repeat (3000) @(posedge mclk);
      n_fail++;
      report_and_stop;
   end

   initial
   begin
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      for (int i = 0; i < 10; i++)
         rchk(ra[i], rv[i]);
      for (int i = 0; i < 10; i++)
      begin
         if (i != 8)
         begin
            wr(ra[i], 16'hFFFF);
            rchk(ra[i], rm[i]);
         end
      end
      wr(16'h0046, 16'h0000);
      wr(16'h0050, 16'h0000);
      wr(16'h0004, 16'h0100);
      wr(16'h0006, 16'h0010);
      xop(3'h2, 4'h2, 10'h000, 4'h0, 16'h0000);
      `CHK(x_ea, 16'h0100)
      rchk(16'h0004, 16'h0100);
      xop(3'h3, 4'h2, 10'h000, 4'h0, 16'h0000);
      `CHK(x_ea, 16'h0100)
      rchk(16'h0004, 16'h0102);
      xop(3'h4, 4'h2, 10'h000, 4'h3, 16'h0000);
      `CHK(x_ea, 16'h0101)
      rchk(16'h0004, 16'h0101);
      xop(3'h5, 4'h2, 10'h000, 4'h0, 16'h0000);
      `CHK(x_ea, 16'h0111)
      xop(3'h6, 4'h2, 10'h3FF, 4'h0, 16'h0000);
      `CHK(x_ea, 16'h0500)
      xop(3'h1, 4'h2, 10'h000, 4'h0, 16'h0000);
      `CHK(x_operand, 16'h0101)
      xop(3'h0, 4'h0, 10'h000, 4'h0, 16'hFFFF);
      `CHK(x_ea, 16'h1FFF)
      xop(3'h0, 4'h0, 10'h000, 4'h8, 16'hFFFF);
      `CHK(x_ea, 16'hFFFF)
      xop(3'h7, 4'h0, 10'h3FF, 4'h0, 16'h0000);
      `CHK(x_operand, 16'h001F)
      xop(3'h7, 4'h0, 10'h3FF, 4'h4, 16'h0000);
      `CHK(x_operand, 16'h03FF)
      // Both paths in one cycle, then a Y request outside the mac class
      wr(16'h0014, 16'h0200);
      @(posedge mclk);
      xs(3'h3, 4'h2, 10'h000, 4'h0, 16'h0000);
      ys(1'b1, 2'h1, 4'hA);
      go;
      `CHK({x_valid, y_valid, x_ea, y_ea}, {2'h3, 32'h01010200})
      @(posedge mclk);
      ys(1'b0, 2'h1, 4'hA);
      go;
      `CHK(y_valid, 1'b0)
      rchk(16'h0014, 16'h0202);
      `CHK({y_count, y_last}, 24'h010200)
      // Circular X and Y buffers wrap; X select 15 turns X off
      wr(16'h0048, 16'h0100);
      wr(16'h004A, 16'h0103);
      wr(16'h0046, 16'h8002);
      wr(16'h0004, 16'h0102);
      xop(3'h3, 4'h2, 10'h000, 4'h0, 16'h0000);
      rchk(16'h0004, 16'h0100);
      wr(16'h0046, 16'h800F);
      wr(16'h0004, 16'h0102);
      xop(3'h3, 4'h2, 10'h000, 4'h0, 16'h0000);
      rchk(16'h0004, 16'h0104);
      wr(16'h004C, 16'h0200);
      wr(16'h004E, 16'h0203);
      wr(16'h0046, 16'h40A0);
      wr(16'h0014, 16'h0202);
      @(posedge mclk);
      ys(1'b1, 2'h1, 4'hA);
      go;
      `CHK(y_ea, 16'h0202)
      rchk(16'h0014, 16'h0200);
      // Bit-reversed X pointer; program space falls back to linear
      wr(16'h0050, 16'h8004);
      wr(16'h0046, 16'h02FF);
      wr(16'h0004, 16'h0100);
      xop(3'h3, 4'h2, 10'h000, 4'h0, 16'h0000);
      `CHK(x_ea, 16'h0100)
      xop(3'h3, 4'h2, 10'h000, 4'h0, 16'h0000);
      `CHK(x_ea, 16'h0108)
      rchk(16'h0004, 16'h0104);
      x_prog_space <= 1'b1;
      xop(3'h3, 4'h2, 10'h000, 4'h0, 16'h0000);
      rchk(16'h0004, 16'h0106);
      x_prog_space <= 1'b0;
      // Y pointer plus offset register; pointer left alone
      wr(16'h0016, 16'h0004);
      y_ofs_sel <= 4'hB;
      @(posedge mclk);
      ys(1'b1, 2'h2, 4'hA);
      go;
      `CHK(y_ea, 16'h0204)
      rchk(16'h0014, 16'h0200);
      // Write-back to W0, then a pair into W6/W7 read as first source
      wbw(1'b1, 1'b0, 4'h0, 16'h1234, 16'h0000);
      rchk(16'h0000, 16'h1234);
      `CHK(default_working_register, 16'h1234)
      wbw(1'b0, 1'b1, 4'h6, 16'hAAAA, 16'h5555);
      src1_sel <= 4'h7;
      rchk(16'h000C, 16'hAAAA);
      rchk(16'h000E, 16'h5555);
      `CHK(src1_data, 16'h5555)
      report_and_stop;
   end
endmodule // test_dual_address_generator
